//--- clock_power_mode_control.sv
// clock source selection, bus dividers and low-power mode sequencing
`timescale 1ns/100ps
module clock_power_mode_control (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rstn,
    // software configuration
    input  wire clock_power_pkg::clk_cfg_s clk_cfg,
    input  wire clock_power_pkg::pwr_cfg_s pwr_cfg,
    input  wire logic                      irq_or_event,
    input  wire logic                      fail_flag_clr,
    input  wire logic                      pvd_flag_clr,
    // analog and pin inputs, asynchronous
    input  wire logic                      ext_osc_ready,
    input  wire logic                      mult_ready,
    input  wire logic                      ext_osc_fail,
    input  wire logic                      supply_low,
    input  wire logic                      supply_out_of_range,
    input  wire logic                      wakeup_pin,
    input  wire logic                      external_reset_pin_n,
    input  wire logic                      watchdog_reset,
    input  wire logic                      rtc_event,
    input  wire logic                      usb_wake,
    input  wire logic [15:0]               ext_lines,
    // clock tree
    output logic [1:0]                     root_src,
    output logic                           int_osc_en,
    output logic                           ext_osc_en,
    output logic                           mult_en,
    output logic                           mult_src_ext,
    output logic [3:0]                     mult_factor,
    output logic [3:0]                     mult_divide,
    output logic                           hclk_en,
    output logic                           pclk_slow_en,
    output logic                           pclk_fast_en,
    output logic                           usb_clk_en,
    // power
    output logic                           core_clk_en,
    output logic                           periph_clk_en,
    output logic [1:0]                     regulator_mode,
    output logic [2:0]                     pvd_threshold,
    output clock_power_pkg::pwr_state_e    pwr_state,
    output logic                           system_reset_hold,
    output logic                           standby_wake_rst,
    // status and interrupts
    output logic                           fail_flag,
    output logic                           fail_irq,
    output logic                           pvd_flag,
    output logic                           pvd_irq
);
    localparam int NS = clock_power_pkg::NSYNC;

    logic [NS-1:0] raw_in;
    logic [NS-1:0] sync1_reg;
    logic [NS-1:0] sync2_reg;
    logic [NS-1:0] prev_reg;
    logic [NS-1:0] rise;

    clock_power_pkg::pwr_state_e state_reg, state_next;
    logic [1:0] src_reg, src_next;
    logic       fail_reg, fail_next, pvd_reg, pvd_next;
    logic       wake_rst_reg, wake_rst_next;
    logic [7:0] ahb_cnt_reg, ahb_cnt_next;
    logic [7:0] slow_peripheral_bus_cnt_reg, slow_peripheral_bus_cnt_next;
    logic [7:0] fast_peripheral_bus_cnt_reg, fast_peripheral_bus_cnt_next;
    logic [1:0] usb_cnt_reg, usb_cnt_next;
    logic       hclk_tick, usb_tick, stop_wake, standby_wake, running;
    logic [1:0] reg_mode_next;

    // outputs from flops
    logic [1:0] src_out_reg;
    logic       int_en_reg, ext_en_reg, mult_en_reg, mult_sel_reg;
    logic [3:0] mult_fac_reg, mult_div_reg;
    logic       hclk_reg, pclk1_reg, pclk2_reg, usb_reg;
    logic       core_reg, periph_reg, rst_hold_reg;
    logic [1:0] reg_mode_reg;
    logic [2:0] pvd_lvl_reg;
    logic       fail_irq_reg, pvd_irq_reg;

    assign raw_in = {ext_lines, usb_wake, rtc_event, watchdog_reset, external_reset_pin_n,
                     wakeup_pin, supply_out_of_range, supply_low, ext_osc_fail, mult_ready, ext_osc_ready};
    // edge detect compares the second stage with prev_reg, its copy one cycle later
    assign rise = sync2_reg & ~prev_reg;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1_reg <= clock_power_pkg::SYNC_RESET;
            sync2_reg <= clock_power_pkg::SYNC_RESET;
            prev_reg  <= clock_power_pkg::SYNC_RESET;
        end else begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    // power-mode sequencing
    always_comb begin
        stop_wake     = |{sync2_reg[NS-1:clock_power_pkg::SY_LINE0], sync2_reg[clock_power_pkg::SY_USB],
                          sync2_reg[clock_power_pkg::SY_RTC], sync2_reg[clock_power_pkg::SY_PVD_OUT]};
        standby_wake  = !sync2_reg[clock_power_pkg::SY_RST_N] || sync2_reg[clock_power_pkg::SY_WDOG]
                        || rise[clock_power_pkg::SY_WAKE_PIN] || sync2_reg[clock_power_pkg::SY_RTC];
        state_next    = state_reg;
        wake_rst_next = 1'b0;
        case (state_reg)
            clock_power_pkg::PM_RUN: begin
                if (pwr_cfg.deep_req) begin
                    state_next = pwr_cfg.standby_sel ? clock_power_pkg::PM_STANDBY : clock_power_pkg::PM_STOP;
                end else if (pwr_cfg.sleep_req) begin
                    state_next = clock_power_pkg::PM_SLEEP;
                end
            end
            clock_power_pkg::PM_SLEEP: begin
                if (irq_or_event) begin
                    state_next = clock_power_pkg::PM_RUN;
                end
            end
            clock_power_pkg::PM_STOP: begin
                if (stop_wake) begin
                    state_next = clock_power_pkg::PM_RUN;
                end
            end
            clock_power_pkg::PM_STANDBY: begin
                // leaving standby restarts the system, so a reset pulse goes out
                if (standby_wake) begin
                    state_next    = clock_power_pkg::PM_RUN;
                    wake_rst_next = 1'b1;
                end
            end
            default: state_next = clock_power_pkg::PM_RUN;
        endcase
        running = (state_next == clock_power_pkg::PM_RUN) || (state_next == clock_power_pkg::PM_SLEEP);
        case (state_next)
            clock_power_pkg::PM_STOP:    reg_mode_next = pwr_cfg.stop_low_pwr ?
                                                         clock_power_pkg::REG_LOW_PWR : clock_power_pkg::REG_MAIN;
            clock_power_pkg::PM_STANDBY: reg_mode_next = clock_power_pkg::REG_OFF;
            default:                     reg_mode_next = clock_power_pkg::REG_MAIN;
        endcase
    end

    // source selection and sticky flags
    always_comb begin
        src_next = src_reg;
        if (!running) begin
            // oscillators are off, so come back on the internal one
            src_next = clock_power_pkg::SRC_INT_FAST;
        end else if (sync2_reg[clock_power_pkg::SY_EXT_FAIL] && src_reg == clock_power_pkg::SRC_EXT_FAST) begin
            src_next = clock_power_pkg::SRC_INT_FAST;
        end else if (sync2_reg[clock_power_pkg::SY_EXT_FAIL] && src_reg == clock_power_pkg::SRC_MULT
                     && clk_cfg.pll_src_ext) begin
            src_next = clock_power_pkg::SRC_INT_FAST;
        end else begin
            case (clk_cfg.src_req)
                clock_power_pkg::SRC_INT_FAST: src_next = clock_power_pkg::SRC_INT_FAST;
                clock_power_pkg::SRC_EXT_FAST: begin
                    if (sync2_reg[clock_power_pkg::SY_EXT_RDY] && !sync2_reg[clock_power_pkg::SY_EXT_FAIL]) begin
                        src_next = clock_power_pkg::SRC_EXT_FAST;
                    end
                end
                clock_power_pkg::SRC_MULT: begin
                    if (sync2_reg[clock_power_pkg::SY_MULT_RDY]) begin
                        src_next = clock_power_pkg::SRC_MULT;
                    end
                end
                default: src_next = src_reg;
            endcase
        end
        // a set in the same cycle as a clear wins
        fail_next = (fail_reg && !fail_flag_clr) || rise[clock_power_pkg::SY_EXT_FAIL];
        pvd_next  = (pvd_reg && !pvd_flag_clr) || rise[clock_power_pkg::SY_PVD_OUT];
    end

    // bus and usb clock enables
    always_comb begin
        hclk_tick     = (ahb_cnt_reg >= clk_cfg.ahb_div);
        ahb_cnt_next  = hclk_tick ? clock_power_pkg::DIV_RESET : ahb_cnt_reg + 8'h01;
        slow_peripheral_bus_cnt_next = slow_peripheral_bus_cnt_reg;
        fast_peripheral_bus_cnt_next = fast_peripheral_bus_cnt_reg;
        if (hclk_tick) begin
            slow_peripheral_bus_cnt_next = (slow_peripheral_bus_cnt_reg >= clk_cfg.slow_peripheral_bus_div) ? clock_power_pkg::DIV_RESET : slow_peripheral_bus_cnt_reg + 8'h01;
            fast_peripheral_bus_cnt_next = (fast_peripheral_bus_cnt_reg >= clk_cfg.fast_peripheral_bus_div) ? clock_power_pkg::DIV_RESET : fast_peripheral_bus_cnt_reg + 8'h01;
        end
        case (clk_cfg.usb_div)
            // 2 pulses in 3 cycles for the 1.5 ratio
            clock_power_pkg::USB_DIV_1P5: begin
                usb_tick     = (usb_cnt_reg != 2'h2);
                usb_cnt_next = (usb_cnt_reg >= 2'h2) ? 2'h0 : usb_cnt_reg + 2'h1;
            end
            clock_power_pkg::USB_DIV_2: begin
                usb_tick     = (usb_cnt_reg == 2'h1);
                usb_cnt_next = (usb_cnt_reg >= 2'h1) ? 2'h0 : usb_cnt_reg + 2'h1;
            end
            default: begin
                usb_tick     = 1'b1;
                usb_cnt_next = 2'h0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg    <= clock_power_pkg::PM_RUN;
            src_reg      <= clock_power_pkg::SRC_RESET;
            fail_reg     <= 1'b0;
            pvd_reg      <= 1'b0;
            wake_rst_reg <= 1'b0;
            ahb_cnt_reg  <= clock_power_pkg::DIV_RESET;
            slow_peripheral_bus_cnt_reg <= clock_power_pkg::DIV_RESET;
            fast_peripheral_bus_cnt_reg <= clock_power_pkg::DIV_RESET;
            usb_cnt_reg  <= 2'h0;
            src_out_reg  <= clock_power_pkg::SRC_RESET;
            int_en_reg   <= 1'b1;
            ext_en_reg   <= 1'b0;
            mult_en_reg  <= 1'b0;
            mult_sel_reg <= 1'b0;
            mult_fac_reg <= 4'h0;
            mult_div_reg <= 4'h0;
            hclk_reg     <= 1'b0;
            pclk1_reg    <= 1'b0;
            pclk2_reg    <= 1'b0;
            usb_reg      <= 1'b0;
            core_reg     <= 1'b1;
            periph_reg   <= 1'b1;
            rst_hold_reg <= 1'b0;
            reg_mode_reg <= clock_power_pkg::REG_MAIN;
            pvd_lvl_reg  <= 3'h0;
            fail_irq_reg <= 1'b0;
            pvd_irq_reg  <= 1'b0;
        end else begin
            state_reg    <= state_next;
            src_reg      <= src_next;
            fail_reg     <= fail_next;
            pvd_reg      <= pvd_next;
            wake_rst_reg <= wake_rst_next;
            ahb_cnt_reg  <= ahb_cnt_next;
            slow_peripheral_bus_cnt_reg <= slow_peripheral_bus_cnt_next;
            fast_peripheral_bus_cnt_reg <= fast_peripheral_bus_cnt_next;
            usb_cnt_reg  <= usb_cnt_next;
            src_out_reg  <= src_next;
            int_en_reg   <= running;
            ext_en_reg   <= running && clk_cfg.ext_osc_on;
            mult_en_reg  <= running && clk_cfg.pll_on;
            mult_sel_reg <= clk_cfg.pll_src_ext;
            mult_fac_reg <= clk_cfg.pll_mul;
            mult_div_reg <= clk_cfg.pll_div;
            hclk_reg     <= running && hclk_tick;
            pclk1_reg    <= running && hclk_tick && (slow_peripheral_bus_cnt_reg >= clk_cfg.slow_peripheral_bus_div);
            pclk2_reg    <= running && hclk_tick && (fast_peripheral_bus_cnt_reg >= clk_cfg.fast_peripheral_bus_div);
            usb_reg      <= running && clk_cfg.pll_on && usb_tick;
            core_reg     <= (state_next == clock_power_pkg::PM_RUN);
            periph_reg   <= running;
            rst_hold_reg <= sync2_reg[clock_power_pkg::SY_PDR_LOW];
            reg_mode_reg <= reg_mode_next;
            pvd_lvl_reg  <= pwr_cfg.pvd_level;
            fail_irq_reg <= fail_next && pwr_cfg.fail_irq_en;
            pvd_irq_reg  <= pvd_next && pwr_cfg.pvd_irq_en;
        end
    end

    assign root_src          = src_out_reg;
    assign int_osc_en        = int_en_reg;
    assign ext_osc_en        = ext_en_reg;
    assign mult_en           = mult_en_reg;
    assign mult_src_ext      = mult_sel_reg;
    assign mult_factor       = mult_fac_reg;
    assign mult_divide       = mult_div_reg;
    assign hclk_en           = hclk_reg;
    assign pclk_slow_en      = pclk1_reg;
    assign pclk_fast_en      = pclk2_reg;
    assign usb_clk_en        = usb_reg;
    assign core_clk_en       = core_reg;
    assign periph_clk_en     = periph_reg;
    assign regulator_mode    = reg_mode_reg;
    assign pvd_threshold     = pvd_lvl_reg;
    assign pwr_state         = state_reg;
    assign system_reset_hold = rst_hold_reg;
    assign standby_wake_rst  = wake_rst_reg;
    assign fail_flag         = fail_reg;
    assign fail_irq          = fail_irq_reg;
    assign pvd_flag          = pvd_reg;
    assign pvd_irq           = pvd_irq_reg;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_pdr_reset_hold: assert property (sync2_reg[3] |=> system_reset_hold)
        else $error("reset not held on low supply");
    a_fail_to_int: assert property (sync2_reg[2] && src_reg == 2'h1 |=> root_src == 2'h0 && src_reg == 2'h0)
        else $error("no fallback on oscillator failure");
    a_fail_irq_out: assert property (rise[2] && pwr_cfg.fail_irq_en |=> fail_irq && fail_flag)
        else $error("failure interrupt missing");
    a_switch_stable: assert property ($changed(src_reg) && src_reg == 2'h2 |-> $past(sync2_reg[1]))
        else $error("switched to unstable multiplier");
    a_sleep_clocks: assert property (state_reg == clock_power_pkg::PM_SLEEP |-> !core_clk_en && periph_clk_en)
        else $error("sleep clocks wrong");
    a_stop_osc_off: assert property (state_reg == clock_power_pkg::PM_STOP
                                     |-> !ext_osc_en && !mult_en && !int_osc_en && !periph_clk_en)
        else $error("oscillator running in stop");
    a_stop_wake_line: assert property (state_reg == clock_power_pkg::PM_STOP && |sync2_reg[NS-1:10]
                                       |=> pwr_state == clock_power_pkg::PM_RUN ##1 core_clk_en)
        else $error("stop did not wake");
    a_standby_wake_rst: assert property (state_reg == clock_power_pkg::PM_STANDBY && sync2_reg[7]
                                         |=> standby_wake_rst ##1 !standby_wake_rst)
        else $error("standby wake reset missing");
    a_standby_reg_off: assert property (state_reg == clock_power_pkg::PM_STANDBY |-> regulator_mode == 2'h2)
        else $error("regulator on in standby");
    a_pvd_irq_out: assert property (rise[4] && pwr_cfg.pvd_irq_en |=> pvd_irq)
        else $error("supply interrupt missing");
    a_usb_half: assert property (usb_tick && clk_cfg.usb_div == clock_power_pkg::USB_DIV_2
                                 ##1 clk_cfg.usb_div == clock_power_pkg::USB_DIV_2 |-> !usb_tick)
        else $error("usb divide by two broken");

    c_sleep_cycle: cover property (state_reg == clock_power_pkg::PM_SLEEP ##1 state_reg == clock_power_pkg::PM_RUN);
    c_stop_cycle: cover property (state_reg == clock_power_pkg::PM_STOP ##1 state_reg == clock_power_pkg::PM_RUN);
    c_standby_wake: cover property (standby_wake_rst);
    c_fail_switch: cover property (src_reg == 2'h1 ##1 src_reg == 2'h0 && fail_flag);
endmodule : clock_power_mode_control

//--- clock_power_mode_control_bench.sv
// self-checking bench for the clock and power-mode controller
`timescale 1ns/100ps
module clock_power_mode_control_bench;
    logic clk, rstn, irq_or_event, fail_flag_clr, pvd_flag_clr, ext_osc_ready, mult_ready, ext_osc_fail;
    logic supply_low, supply_out_of_range, wakeup_pin, external_reset_pin_n, watchdog_reset, rtc_event;
    logic usb_wake, mult_en, mult_src_ext, hclk_en, pclk_slow_en, pclk_fast_en, usb_clk_en, core_clk_en;
    logic int_osc_en, ext_osc_en, periph_clk_en, system_reset_hold, standby_wake_rst;
    logic fail_flag, fail_irq, pvd_flag, pvd_irq;
    logic [15:0] ext_lines;
    logic [1:0]  root_src, regulator_mode;
    logic [3:0]  mult_factor, mult_divide;
    logic [2:0]  pvd_threshold;
    clock_power_pkg::clk_cfg_s   clk_cfg;
    clock_power_pkg::pwr_cfg_s   pwr_cfg;
    clock_power_pkg::pwr_state_e pwr_state;
    int fail_count, compares;

    clock_power_mode_control clock_power_mode_control_inst (.clk, .rstn, .clk_cfg, .pwr_cfg, .irq_or_event,
        .fail_flag_clr, .pvd_flag_clr, .ext_osc_ready, .mult_ready, .ext_osc_fail, .supply_low,
        .supply_out_of_range, .wakeup_pin, .external_reset_pin_n, .watchdog_reset, .rtc_event, .usb_wake,
        .ext_lines, .root_src, .int_osc_en, .ext_osc_en, .mult_en, .mult_src_ext, .mult_factor, .mult_divide,
        .hclk_en, .pclk_slow_en, .pclk_fast_en, .usb_clk_en, .core_clk_en, .periph_clk_en, .regulator_mode,
        .pvd_threshold, .pwr_state, .system_reset_hold, .standby_wake_rst, .fail_flag, .fail_irq, .pvd_flag,
        .pvd_irq);

    always #5 clk = ~clk;

    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task conclude;
        $display("mismatches %0d, comparisons %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude

    // bounded wait until the root source reaches a value
    task wait_src(input logic [1:0] s);
        for (int i = 0; i < 10 && root_src !== s; i++) begin
            @(posedge clk);
            #1;
        end
    endtask : wait_src

    task clock_switch;
        @(posedge clk);
        clk_cfg.ext_osc_on <= 1'b1;
        clk_cfg.src_req    <= clock_power_pkg::SRC_EXT_FAST;
        pwr_cfg.fail_irq_en <= 1'b1;
        repeat (5) @(posedge clk);
        #1 check(root_src, clock_power_pkg::SRC_INT_FAST);
        @(posedge clk) ext_osc_ready <= 1'b1;
        wait_src(clock_power_pkg::SRC_EXT_FAST);
        check(root_src, clock_power_pkg::SRC_EXT_FAST);
        // software still asks for the external osc, so only the failure can move it back
        @(posedge clk) ext_osc_fail <= 1'b1;
        wait_src(clock_power_pkg::SRC_INT_FAST);
        check(root_src, clock_power_pkg::SRC_INT_FAST);
        #20 check({fail_flag, fail_irq}, 2'b11);
        @(posedge clk) ext_osc_fail <= 1'b0;
        clk_cfg.src_req <= clock_power_pkg::SRC_INT_FAST;
        fail_flag_clr <= 1'b1;
        repeat (5) @(posedge clk);
        #1 check(fail_flag, 1'b0);
        @(posedge clk) fail_flag_clr <= 1'b0;
        clk_cfg.pll_on <= 1'b1;
        clk_cfg.pll_mul <= 4'h5;
        clk_cfg.pll_div <= 4'h3;
        mult_ready <= 1'b1;
        clk_cfg.src_req <= clock_power_pkg::SRC_MULT;
        wait_src(clock_power_pkg::SRC_MULT);
        check(root_src, clock_power_pkg::SRC_MULT);
        check({mult_en, mult_src_ext, mult_factor, mult_divide}, 10'h253);
    endtask : clock_switch

    // ticks counted over 24 cycles for each usb divider choice
    task dividers;
        int h, s, f, u;
        clk_cfg.ahb_div <= 8'h02;
        clk_cfg.slow_peripheral_bus_div <= 8'h01;
        clk_cfg.fast_peripheral_bus_div <= 8'h00;
        for (int d = 0; d < 3; d++) begin
            @(posedge clk) clk_cfg.usb_div <= d[1:0];
            {h, s, f, u} = '0;
            repeat (6) @(posedge clk);
            repeat (24) begin
                @(posedge clk);
                #1;
                h += hclk_en;
                s += pclk_slow_en;
                f += pclk_fast_en;
                u += usb_clk_en;
            end
            check({h[7:0], s[7:0], f[7:0]}, 24'h08_0408);
            check(u, (d == 0) ? 24 : (d == 1) ? 16 : 12);
        end
    endtask : dividers

    task sleep_wake;
        @(posedge clk) pwr_cfg.sleep_req <= 1'b1;
        @(posedge clk) pwr_cfg.sleep_req <= 1'b0;
        #1 check({pwr_state, core_clk_en, periph_clk_en}, {clock_power_pkg::PM_SLEEP, 2'b01});
        @(posedge clk) irq_or_event <= 1'b1;
        @(posedge clk) irq_or_event <= 1'b0;
        #1 check(pwr_state, clock_power_pkg::PM_RUN);
    endtask : sleep_wake

    task set_wake(input logic stby, input int k, input logic v);
        if (stby) case (k)
            0: external_reset_pin_n <= !v;
            1: watchdog_reset <= v;
            2: wakeup_pin <= v;
            default: rtc_event <= v;
        endcase
        else case (k)
            0: ext_lines <= v ? 16'h0020 : 16'h0000;
            1: usb_wake <= v;
            2: rtc_event <= v;
            default: supply_out_of_range <= v;
        endcase
    endtask : set_wake

    task low_power(input logic stby, input int k);
        logic pulse;
        pulse = 1'b0;
        @(posedge clk);
        pwr_cfg.deep_req <= 1'b1;
        pwr_cfg.standby_sel <= stby;
        pwr_cfg.stop_low_pwr <= k[0];
        // oscillators stop here, so their ready flags drop and stay low
        ext_osc_ready <= 1'b0;
        mult_ready <= 1'b0;
        @(posedge clk) pwr_cfg.deep_req <= 1'b0;
        #1 check(pwr_state, stby ? clock_power_pkg::PM_STANDBY : clock_power_pkg::PM_STOP);
        check(regulator_mode, stby ? clock_power_pkg::REG_OFF :
              (k[0] ? clock_power_pkg::REG_LOW_PWR : clock_power_pkg::REG_MAIN));
        check({core_clk_en, int_osc_en, ext_osc_en, mult_en}, 4'h0);
        @(posedge clk) set_wake(stby, k, 1'b1);
        for (int i = 0; i < 10 && pwr_state !== clock_power_pkg::PM_RUN; i++) begin
            @(posedge clk);
            #1 pulse |= (standby_wake_rst === 1'b1);
        end
        check({pwr_state, regulator_mode, root_src}, {clock_power_pkg::PM_RUN, 4'h0});
        check(pulse, stby);
        @(posedge clk) set_wake(stby, k, 1'b0);
        repeat (4) @(posedge clk);
    endtask : low_power

    task supply;
        @(posedge clk) supply_low <= 1'b1;
        pwr_cfg.pvd_irq_en <= 1'b1;
        pwr_cfg.pvd_level <= 3'h5;
        repeat (4) @(posedge clk);
        #1 check(system_reset_hold, 1'b1);
        @(posedge clk) supply_low <= 1'b0;
        supply_out_of_range <= 1'b1;
        repeat (4) @(posedge clk);
        #1 check({system_reset_hold, pvd_flag, pvd_irq, pvd_threshold}, 6'h1d);
        @(posedge clk) supply_out_of_range <= 1'b0;
        pvd_flag_clr <= 1'b1;
        repeat (4) @(posedge clk);
        #1 check(pvd_flag, 1'b0);
        @(posedge clk) pvd_flag_clr <= 1'b0;
    endtask : supply

    initial begin
        {clk, rstn, irq_or_event, fail_flag_clr, pvd_flag_clr, ext_osc_ready, mult_ready} = '0;
        {ext_osc_fail, supply_low, supply_out_of_range, wakeup_pin, watchdog_reset, rtc_event, usb_wake} = '0;
        {clk_cfg, pwr_cfg, ext_lines, fail_count, compares} = '0;
        external_reset_pin_n = 1'b1;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1 check({root_src, regulator_mode, pwr_state, int_osc_en}, 7'h01);
        clock_switch();
        dividers();
        sleep_wake();
        supply();
        for (int k = 0; k < 8; k++) low_power(k[2], k % 4);
        conclude();
    end

    // the whole sequence needs well under 2000 cycles
    initial begin
        #50000;
        fail_count++;
        conclude();
    end
endmodule : clock_power_mode_control_bench

//--- clock_power_pkg.sv
// constants and carrier types for the clock and power-mode controller
package clock_power_pkg;
    // root clock sources
    localparam logic [1:0] SRC_INT_FAST = 2'h0;
    localparam logic [1:0] SRC_EXT_FAST = 2'h1;
    localparam logic [1:0] SRC_MULT     = 2'h2;
    localparam logic [1:0] SRC_RESET    = SRC_INT_FAST;
    // usb divider choices
    localparam logic [1:0] USB_DIV_1    = 2'h0;
    localparam logic [1:0] USB_DIV_1P5  = 2'h1;
    localparam logic [1:0] USB_DIV_2    = 2'h2;
    // regulator modes
    localparam logic [1:0] REG_MAIN     = 2'h0;
    localparam logic [1:0] REG_LOW_PWR  = 2'h1;
    localparam logic [1:0] REG_OFF      = 2'h2;
    // synchroniser bit positions
    localparam int SY_EXT_RDY  = 0;
    localparam int SY_MULT_RDY = 1;
    localparam int SY_EXT_FAIL = 2;
    localparam int SY_PDR_LOW  = 3;
    localparam int SY_PVD_OUT  = 4;
    localparam int SY_WAKE_PIN = 5;
    localparam int SY_RST_N    = 6;
    localparam int SY_WDOG     = 7;
    localparam int SY_RTC      = 8;
    localparam int SY_USB      = 9;
    localparam int SY_LINE0    = 10;
    localparam int NUM_LINES   = 16;
    localparam int NSYNC       = SY_LINE0 + NUM_LINES;
    localparam logic [NSYNC-1:0] SYNC_RESET = 26'h000_0040;
    localparam logic [7:0] DIV_RESET = 8'h00;

    typedef enum logic [1:0] {
        PM_RUN     = 2'b00,
        PM_SLEEP   = 2'b01,
        PM_STOP    = 2'b11,
        PM_STANDBY = 2'b10
    } pwr_state_e;

    typedef struct packed {
        logic [1:0] src_req;
        logic       pll_src_ext;
        logic [3:0] pll_mul;
        logic [3:0] pll_div;
        logic [7:0] ahb_div;
        logic [7:0] slow_peripheral_bus_div;
        logic [7:0] fast_peripheral_bus_div;
        logic [1:0] usb_div;
        logic       ext_osc_on;
        logic       pll_on;
    } clk_cfg_s;

    typedef struct packed {
        logic       sleep_req;
        logic       deep_req;
        logic       standby_sel;
        logic       stop_low_pwr;
        logic       fail_irq_en;
        logic       pvd_irq_en;
        logic [2:0] pvd_level;
    } pwr_cfg_s;
endpackage : clock_power_pkg
